// File: rtl/fdms_cfg.svh
// Constants of the flash data memory sequencer: offsets, fields, resets and timing
`ifndef FDMS_CFG_SVH
`define FDMS_CFG_SVH

// ------------------------------------------------------------
// Clock and operation times
// ------------------------------------------------------------
`define FDMS_CLK_NS 20.0
`define FDMS_MC_NS 20.0
`define FDMS_T_RDPAGE_MC 22
`define FDMS_T_VERIFY_MC 22
`define FDMS_T_RDBYTE_MC 9
`define FDMS_T_WRPAGE_US 380
`define FDMS_T_ERPAGE_MS 2
`define FDMS_T_ERALL_MS 2
`define FDMS_T_WRBYTE_US 200
`define FDMS_T_PM_WRPAGE_MS 16.5
`define FDMS_T_PM_ERPAGE_MS 2
`define FDMS_T_PM_ERALL_MS 2
`define FDMS_T_PM_WRBYTE_US 200
`define FDMS_ERALL_MIN_CYC 1024
`define FDMS_CNT_W 20

// ------------------------------------------------------------
// Array and special function register selects
// ------------------------------------------------------------
`define FDMS_DMEM_BYTES 4096
`define FDMS_SFR_CMD 3'h0
`define FDMS_SFR_ADDRH 3'h1
`define FDMS_SFR_ADDRL 3'h2
`define FDMS_SFR_DATA1 3'h3
`define FDMS_SFR_DATA4 3'h6

// ------------------------------------------------------------
// Reset and result values
// ------------------------------------------------------------
`define FDMS_RST_BYTE 8'h00
`define FDMS_ERASED 8'hff
`define FDMS_VERIFY_FAIL 8'h01
`define FDMS_BOOT_ERASE 1'b1

// ------------------------------------------------------------
// Controller APB map and sequence steps
// ------------------------------------------------------------
`define FDMS_APB_ADDR 8'h00
`define FDMS_APB_DATA 8'h04
`define FDMS_APB_CMD 8'h08
`define FDMS_APB_STAT 8'h0c
`define FDMS_STEP_CMD 3'h6
`define FDMS_STEP_RD_LAST 3'h4
`define FDMS_STEP_END 3'h6

`endif

// File: rtl/fdms_core.sv
// Flash sequencer core end: APB registers driving the register-port sequence
`include "fdms_cfg.svh"
module fdms_core (
	input wire logic CLK, // System clock, 50 MHz
	input wire logic RST, // Asynchronous reset, high
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB access phase
	input wire logic PWRITE, // APB direction
	input wire logic [7:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error
	fdms_if.core SFR // Register port to the sequencer
);
	import fdms_pkg::*;

	fdms_host_state_t hs_reg;
	fdms_host_state_t hs_next;
	logic [2:0] step_reg;
	logic [2:0] step_next;
	logic [15:0] addr_reg;
	logic [15:0] addr_next;
	logic [31:0] data_reg;
	logic [31:0] data_next;
	logic [31:0] rback_reg;
	logic [31:0] rback_next;
	fdms_byte_t cmd_reg;
	fdms_byte_t cmd_next;
	fdms_byte_t rcmd_reg;
	fdms_byte_t rcmd_next;
	logic fail_reg;
	logic fail_next;
	logic boot_reg;
	logic boot_next;
	logic wr_reg;
	logic wr_next;
	logic rd_reg;
	logic rd_next;
	fdms_sel_t sel_reg;
	fdms_sel_t sel_next;
	fdms_byte_t wdata_reg;
	fdms_byte_t wdata_next;
	logic cap_vld_reg;
	fdms_sel_t cap_sel_reg;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic setup;
	logic access;
	logic hbusy;
	logic [1:0] cap_idx;
	logic [1:0] snd_idx;

	assign setup = PSEL && !PENABLE;
	assign access = PSEL && PENABLE && pready_reg;
	assign hbusy = (hs_reg != FDMS_H_IDLE) || boot_reg;
	assign cap_idx = 2'(cap_sel_reg - `FDMS_SFR_DATA1);
	assign snd_idx = 2'(step_reg - 3'h2);

	// ------------------------------------------------------------
	// APB slave and port sequence
	// ------------------------------------------------------------
	always_comb begin
		hs_next = hs_reg;
		step_next = step_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		rback_next = rback_reg;
		cmd_next = cmd_reg;
		rcmd_next = rcmd_reg;
		fail_next = fail_reg;
		boot_next = boot_reg;
		wr_next = 1'b0;
		rd_next = 1'b0;
		sel_next = sel_reg;
		wdata_next = wdata_reg;
		prdata_next = prdata_reg;
		pslverr_next = 1'b0;
		// Ready one cycle after setup: every access has one wait-free access cycle
		pready_next = setup;
		if (setup) begin
			if (PADDR == `FDMS_APB_ADDR) begin
				prdata_next = {16'h0000, addr_reg};
			end else if (PADDR == `FDMS_APB_DATA) begin
				prdata_next = rback_reg;
			end else if (PADDR == `FDMS_APB_CMD) begin
				prdata_next = {24'h000000, cmd_reg};
				pslverr_next = PWRITE && hbusy;
			end else if (PADDR == `FDMS_APB_STAT) begin
				prdata_next = {16'h0000, rcmd_reg, 6'h00, fail_reg, hbusy};
			end else begin
				prdata_next = 32'h00000000;
				pslverr_next = 1'b1;
			end
		end
		if (access && PWRITE) begin
			if (PADDR == `FDMS_APB_ADDR) begin
				addr_next = PWDATA[15:0];
			end else if (PADDR == `FDMS_APB_DATA) begin
				data_next = PWDATA;
			end else if ((PADDR == `FDMS_APB_CMD) && !hbusy) begin
				cmd_next = PWDATA[7:0];
				fail_next = 1'b0;
				hs_next = FDMS_H_WRITE;
				step_next = 3'h0;
			end
		end
		case (hs_reg)
			FDMS_H_IDLE: begin
				if (boot_reg) begin
					boot_next = 1'b0;
					cmd_next = FDMS_FULL_ARRAY_ERASE;
					hs_next = FDMS_H_WRITE;
					step_next = `FDMS_STEP_CMD;
				end
			end
			FDMS_H_WRITE: begin
				// Address first, then data bytes, command last
				wr_next = 1'b1;
				if (step_reg == 3'h0) begin
					sel_next = `FDMS_SFR_ADDRH;
					wdata_next = addr_reg[15:8];
				end else if (step_reg == 3'h1) begin
					sel_next = `FDMS_SFR_ADDRL;
					wdata_next = addr_reg[7:0];
				end else if (step_reg < `FDMS_STEP_CMD) begin
					sel_next = 3'(step_reg + 3'h1);
					wdata_next = data_reg[{snd_idx, 3'b000} +: 8];
				end else begin
					sel_next = `FDMS_SFR_CMD;
					wdata_next = cmd_reg;
				end
				step_next = (step_reg == `FDMS_STEP_CMD) ? 3'h0 : 3'(step_reg + 3'h1);
				hs_next = (step_reg == `FDMS_STEP_CMD) ? FDMS_H_WAIT : FDMS_H_WRITE;
			end
			FDMS_H_WAIT: begin
				// One settle cycle, since busy rises one edge after the command
				if (step_reg == 3'h0) begin
					step_next = 3'h1;
				end else if (!SFR.busy) begin
					hs_next = FDMS_H_READ;
					step_next = 3'h0;
				end
			end
			FDMS_H_READ: begin
				if (step_reg <= `FDMS_STEP_RD_LAST) begin
					rd_next = 1'b1;
					sel_next = (step_reg == 3'h0) ? `FDMS_SFR_CMD : 3'(step_reg + 3'h2);
				end
				step_next = 3'(step_reg + 3'h1);
				if (step_reg == `FDMS_STEP_END) begin
					hs_next = FDMS_H_IDLE;
				end
			end
			default: hs_next = FDMS_H_IDLE;
		endcase
		// Read data arrives one cycle after each strobe
		if (cap_vld_reg) begin
			if (cap_sel_reg == `FDMS_SFR_CMD) begin
				rcmd_next = SFR.sfr_rdata;
				fail_next = (cmd_reg == FDMS_VERIFY) && (SFR.sfr_rdata != `FDMS_RST_BYTE);
			end else begin
				rback_next[{cap_idx, 3'b000} +: 8] = SFR.sfr_rdata;
			end
		end
	end

	// Controller registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			hs_reg <= FDMS_H_IDLE;
			step_reg <= 3'h0;
			addr_reg <= 16'h0000;
			data_reg <= 32'h00000000;
			rback_reg <= 32'h00000000;
			cmd_reg <= `FDMS_RST_BYTE;
			rcmd_reg <= `FDMS_RST_BYTE;
			fail_reg <= 1'b0;
			boot_reg <= `FDMS_BOOT_ERASE;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			sel_reg <= `FDMS_SFR_CMD;
			wdata_reg <= `FDMS_RST_BYTE;
			cap_vld_reg <= 1'b0;
			cap_sel_reg <= `FDMS_SFR_CMD;
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			hs_reg <= hs_next;
			step_reg <= step_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			rback_reg <= rback_next;
			cmd_reg <= cmd_next;
			rcmd_reg <= rcmd_next;
			fail_reg <= fail_next;
			boot_reg <= boot_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			sel_reg <= sel_next;
			wdata_reg <= wdata_next;
			cap_vld_reg <= rd_reg;
			cap_sel_reg <= sel_reg;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign SFR.sfr_wr = wr_reg;
	assign SFR.sfr_rd = rd_reg;
	assign SFR.sfr_sel = sel_reg;
	assign SFR.sfr_wdata = wdata_reg;
	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
endmodule

// File: rtl/fdms_flash.sv
// Flash data memory sequencer: device end with its registers and data array
`include "fdms_cfg.svh"

// ------------------------------------------------------------
// Flash sequencer device end
// ------------------------------------------------------------
// Notes on behaviour
// - Core loads address, data, then command
// - Two registers hold address high, low
// - Core reads page, patches one byte
// - Programming only clears bits of erased bytes
// - Erase covers a whole four-byte page
// - Code 06H erases whole data array
// - Full erase lasts about two milliseconds
// - Data mode read, verify, write times
// - Program mode write and erase times
// - Command write itself starts the operation
// - Core stalled until operation finishes
// - Interrupts held off while operation runs
// - Peripheral counters keep running during stall
// - Core verifies, then checks command register
// - Core erases whole array at setup
// - Data mode command code decode
// - Verify result zero on match
// - F0H program target, 0FH data target
module fdms_flash #(
	parameter int P_WRPAGE_CYC = int'($ceil(`FDMS_T_WRPAGE_US * 1.0e3 / `FDMS_CLK_NS)), // Page write
	parameter int P_ERPAGE_CYC = int'($ceil(`FDMS_T_ERPAGE_MS * 1.0e6 / `FDMS_CLK_NS)), // Page erase
	parameter int P_ERALL_CYC = int'($ceil(`FDMS_T_ERALL_MS * 1.0e6 / `FDMS_CLK_NS)), // Full erase
	parameter int P_WRBYTE_CYC = int'($ceil(`FDMS_T_WRBYTE_US * 1.0e3 / `FDMS_CLK_NS)), // Byte write
	parameter int P_PM_WRPAGE_CYC = int'($ceil(`FDMS_T_PM_WRPAGE_MS * 1.0e6 / `FDMS_CLK_NS)),
	parameter int P_PM_ERPAGE_CYC = int'($ceil(`FDMS_T_PM_ERPAGE_MS * 1.0e6 / `FDMS_CLK_NS)),
	parameter int P_PM_ERALL_CYC = int'($ceil(`FDMS_T_PM_ERALL_MS * 1.0e6 / `FDMS_CLK_NS)),
	parameter int P_PM_WRBYTE_CYC = int'($ceil(`FDMS_T_PM_WRBYTE_US * 1.0e3 / `FDMS_CLK_NS))
) (
	input wire logic CLK, // System clock, 50 MHz
	input wire logic RST, // Asynchronous reset, high
	fdms_if.flash SFR, // Register port from the core
	input wire logic IRQ_REQ, // Pending interrupt request
	output logic IRQ_TAKE, // Interrupt may be serviced
	output logic PROG_MODE, // Commands target program memory
	output logic [15:0] PERIPH_COUNT // Free-running peripheral counter
);
	import fdms_pkg::*;

	// ------------------------------------------------------------
	// Short operation times and declarations
	// ------------------------------------------------------------
	localparam int RDPAGE_CYC = int'($ceil(`FDMS_T_RDPAGE_MC * `FDMS_MC_NS / `FDMS_CLK_NS));
	localparam int VERIFY_CYC = int'($ceil(`FDMS_T_VERIFY_MC * `FDMS_MC_NS / `FDMS_CLK_NS));
	localparam int RDBYTE_CYC = int'($ceil(`FDMS_T_RDBYTE_MC * `FDMS_MC_NS / `FDMS_CLK_NS));
	// The sweep clears four bytes a cycle, so a full erase never ends before it
	localparam int ERALL_CYC = (P_ERALL_CYC > `FDMS_ERALL_MIN_CYC) ? P_ERALL_CYC :
		`FDMS_ERALL_MIN_CYC;

	fdms_dev_state_t state_reg;
	fdms_dev_state_t state_next;
	fdms_byte_t cmd_reg;
	fdms_byte_t cmd_next;
	fdms_byte_t op_reg;
	fdms_byte_t op_next;
	fdms_byte_t addr_h_reg;
	fdms_byte_t addr_h_next;
	fdms_byte_t addr_l_reg;
	fdms_byte_t addr_l_next;
	fdms_byte_t rdata_reg;
	fdms_byte_t rdata_next;
	fdms_byte_t data_reg [4];
	fdms_byte_t data_next [4];
	logic prog_reg;
	logic prog_next;
	logic busy_reg;
	logic busy_next;
	logic [9:0] walk_reg;
	logic [9:0] walk_next;
	logic irq_reg;
	logic irq_next;
	logic [15:0] periph_reg;
	logic [15:0] periph_next;
	logic tmr_load;
	logic tmr_done;
	fdms_cnt_t tmr_count;
	logic [11:0] page_base;
	logic [11:0] byte_addr;
	logic [11:0] lane_addr [4];
	fdms_byte_t lane_q [4];
	fdms_byte_t lane_wd [4];
	logic [3:0] lane_we;
	logic [3:0] lane_eq;
	logic sweep;
	logic byte_op;
	logic finish;
	fdms_byte_t mem [`FDMS_DMEM_BYTES];

	// Wait length of a command; zero marks a code that starts nothing
	function automatic fdms_cnt_t op_cycles(input fdms_byte_t code, input logic prog);
		op_cycles = '0;
		if (prog) begin
			case (code)
				FDMS_WRITE_PAGE: op_cycles = fdms_cnt_t'(P_PM_WRPAGE_CYC);
				FDMS_ERASE_PAGE: op_cycles = fdms_cnt_t'(P_PM_ERPAGE_CYC);
				FDMS_FULL_ARRAY_ERASE: op_cycles = fdms_cnt_t'(P_PM_ERALL_CYC);
				FDMS_WRITE_BYTE: op_cycles = fdms_cnt_t'(P_PM_WRBYTE_CYC);
				default: op_cycles = '0;
			endcase
		end else begin
			case (code)
				FDMS_READ_PAGE: op_cycles = fdms_cnt_t'(RDPAGE_CYC);
				FDMS_WRITE_PAGE: op_cycles = fdms_cnt_t'(P_WRPAGE_CYC);
				FDMS_VERIFY: op_cycles = fdms_cnt_t'(VERIFY_CYC);
				FDMS_ERASE_PAGE: op_cycles = fdms_cnt_t'(P_ERPAGE_CYC);
				FDMS_FULL_ARRAY_ERASE: op_cycles = fdms_cnt_t'(ERALL_CYC);
				FDMS_READ_BYTE: op_cycles = fdms_cnt_t'(RDBYTE_CYC);
				FDMS_WRITE_BYTE: op_cycles = fdms_cnt_t'(P_WRBYTE_CYC);
				default: op_cycles = '0;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// Array lanes
	// ------------------------------------------------------------
	// Page address is ten bits of the register pair, byte address twelve
	assign page_base = {addr_h_reg[1:0], addr_l_reg, 2'b00};
	assign byte_addr = {addr_h_reg[3:0], addr_l_reg};
	assign byte_op = (op_reg == FDMS_READ_BYTE) || (op_reg == FDMS_WRITE_BYTE);
	assign sweep = busy_reg && !prog_reg && (op_reg == FDMS_FULL_ARRAY_ERASE);
	assign finish = busy_reg && tmr_done && !prog_reg;

	// One lane per byte of a page
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			if (g == 0) begin : g_first
				assign lane_addr[g] = sweep ? {walk_reg, 2'b00} : (byte_op ? byte_addr : page_base);
			end else begin : g_rest
				assign lane_addr[g] = sweep ? {walk_reg, 2'(g)} : (page_base | 12'(g));
			end
			assign lane_q[g] = mem[lane_addr[g]];
			assign lane_eq[g] = (lane_q[g] == data_reg[g]);
		end
	endgenerate

	// Array write enables and data: every cycle of a full-erase sweep, otherwise at the end of an operation
	always_comb begin
		lane_we = 4'h0;
		for (int i = 0; i < 4; i++) begin
			lane_wd[i] = `FDMS_ERASED;
		end
		if (sweep) begin
			lane_we = 4'hf;
		end else if (finish) begin
			case (op_reg)
				FDMS_WRITE_PAGE: begin
					lane_we = 4'hf;
					for (int i = 0; i < 4; i++) begin
						lane_wd[i] = lane_q[i] & data_reg[i];
					end
				end
				FDMS_ERASE_PAGE: lane_we = 4'hf;
				FDMS_WRITE_BYTE: begin
					lane_we = 4'h1;
					lane_wd[0] = lane_q[0] & data_reg[0];
				end
				default: lane_we = 4'h0;
			endcase
		end
	end

	// Array storage; contents are undefined until erased
	always_ff @(posedge CLK) begin
		for (int i = 0; i < 4; i++) begin
			if (lane_we[i]) begin
				mem[lane_addr[i]] <= lane_wd[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Operation timer
	// ------------------------------------------------------------
	fdms_timer u_timer (
		.clk(CLK),
		.rst(RST),
		.load(tmr_load),
		.count(tmr_count),
		.done(tmr_done),
		.running()
	);

	// ------------------------------------------------------------
	// Sequencer and registers
	// ------------------------------------------------------------
	// Next state of registers, commands and results
	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		op_next = op_reg;
		addr_h_next = addr_h_reg;
		addr_l_next = addr_l_reg;
		data_next = data_reg;
		prog_next = prog_reg;
		walk_next = walk_reg;
		rdata_next = rdata_reg;
		tmr_load = 1'b0;
		tmr_count = op_cycles(SFR.sfr_wdata, prog_reg);
		if (SFR.sfr_rd) begin
			if (SFR.sfr_sel == `FDMS_SFR_CMD) begin
				rdata_next = cmd_reg;
			end else if (SFR.sfr_sel == `FDMS_SFR_ADDRH) begin
				rdata_next = addr_h_reg;
			end else if (SFR.sfr_sel == `FDMS_SFR_ADDRL) begin
				rdata_next = addr_l_reg;
			end else if (SFR.sfr_sel <= `FDMS_SFR_DATA4) begin
				rdata_next = data_reg[2'(SFR.sfr_sel - `FDMS_SFR_DATA1)];
			end else begin
				rdata_next = `FDMS_RST_BYTE;
			end
		end
		case (state_reg)
			FDMS_DEV_IDLE: begin
				// Writes while busy cannot occur: the core is stalled
				if (SFR.sfr_wr) begin
					if (SFR.sfr_sel == `FDMS_SFR_CMD) begin
						cmd_next = SFR.sfr_wdata;
						if (SFR.sfr_wdata == FDMS_PROGRAM_MEMORY_TARGET_MODE) begin
							prog_next = 1'b1;
						end else if (SFR.sfr_wdata == FDMS_DATA_MEMORY_TARGET_MODE) begin
							prog_next = 1'b0;
						end else if (tmr_count != '0) begin
							tmr_load = 1'b1;
							op_next = SFR.sfr_wdata;
							state_next = FDMS_DEV_BUSY;
							walk_next = '0;
						end
					end else if (SFR.sfr_sel == `FDMS_SFR_ADDRH) begin
						addr_h_next = SFR.sfr_wdata;
					end else if (SFR.sfr_sel == `FDMS_SFR_ADDRL) begin
						addr_l_next = SFR.sfr_wdata;
					end else if (SFR.sfr_sel <= `FDMS_SFR_DATA4) begin
						data_next[2'(SFR.sfr_sel - `FDMS_SFR_DATA1)] = SFR.sfr_wdata;
					end
				end
			end
			FDMS_DEV_BUSY: begin
				if (sweep) begin
					walk_next = walk_reg + 10'h001;
				end
				if (tmr_done) begin
					state_next = FDMS_DEV_IDLE;
					if (!prog_reg) begin
						case (op_reg)
							FDMS_READ_PAGE: data_next = lane_q;
							FDMS_READ_BYTE: data_next[0] = lane_q[0];
							FDMS_VERIFY: cmd_next = (&lane_eq) ? `FDMS_RST_BYTE : `FDMS_VERIFY_FAIL;
							default: cmd_next = cmd_reg;
						endcase
					end
				end
			end
			default: state_next = FDMS_DEV_IDLE;
		endcase
		busy_next = (state_next == FDMS_DEV_BUSY);
		// Interrupts wait for the end; counters never stop
		irq_next = IRQ_REQ && !busy_next;
		periph_next = periph_reg + 16'h0001;
	end

	// Register bank
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_reg <= FDMS_DEV_IDLE;
			cmd_reg <= `FDMS_RST_BYTE;
			op_reg <= `FDMS_RST_BYTE;
			addr_h_reg <= `FDMS_RST_BYTE;
			addr_l_reg <= `FDMS_RST_BYTE;
			rdata_reg <= `FDMS_RST_BYTE;
			for (int i = 0; i < 4; i++) begin
				data_reg[i] <= `FDMS_RST_BYTE;
			end
			prog_reg <= 1'b0;
			busy_reg <= 1'b0;
			walk_reg <= '0;
			irq_reg <= 1'b0;
			periph_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			op_reg <= op_next;
			addr_h_reg <= addr_h_next;
			addr_l_reg <= addr_l_next;
			rdata_reg <= rdata_next;
			data_reg <= data_next;
			prog_reg <= prog_next;
			busy_reg <= busy_next;
			walk_reg <= walk_next;
			irq_reg <= irq_next;
			periph_reg <= periph_next;
		end
	end

	assign SFR.sfr_rdata = rdata_reg;
	assign SFR.busy = busy_reg;
	assign IRQ_TAKE = irq_reg;
	assign PROG_MODE = prog_reg;
	assign PERIPH_COUNT = periph_reg;
endmodule

// File: rtl/fdms_if.sv
// Register-port link between the core end and the flash sequencer end
interface fdms_if;
	logic sfr_wr; // Register write strobe
	logic sfr_rd; // Register read strobe
	fdms_pkg::fdms_sel_t sfr_sel; // Register select
	fdms_pkg::fdms_byte_t sfr_wdata; // Write data
	fdms_pkg::fdms_byte_t sfr_rdata; // Read data, one cycle after the strobe
	logic busy; // Operation running, core stalled
	modport core (output sfr_wr, sfr_rd, sfr_sel, sfr_wdata, input sfr_rdata, busy);
	modport flash (input sfr_wr, sfr_rd, sfr_sel, sfr_wdata, output sfr_rdata, busy);
endinterface

// File: rtl/fdms_pkg.sv
// Types shared by both ends of the flash data memory sequencer
`include "fdms_cfg.svh"
package fdms_pkg;
	typedef logic [7:0] fdms_byte_t;
	typedef logic [2:0] fdms_sel_t;
	typedef logic [`FDMS_CNT_W-1:0] fdms_cnt_t;
	// Command register codes
	typedef enum logic [7:0] {
		FDMS_READ_PAGE = 8'h01,
		FDMS_WRITE_PAGE = 8'h02,
		FDMS_VERIFY = 8'h04,
		FDMS_ERASE_PAGE = 8'h05,
		FDMS_FULL_ARRAY_ERASE = 8'h06,
		FDMS_READ_BYTE = 8'h81,
		FDMS_WRITE_BYTE = 8'h82,
		FDMS_DATA_MEMORY_TARGET_MODE = 8'h0f,
		FDMS_PROGRAM_MEMORY_TARGET_MODE = 8'hf0
	} fdms_cmd_t;
	typedef enum logic {FDMS_DEV_IDLE, FDMS_DEV_BUSY} fdms_dev_state_t;
	typedef enum logic [1:0] {FDMS_H_IDLE, FDMS_H_WRITE, FDMS_H_WAIT, FDMS_H_READ} fdms_host_state_t;
endpackage

// File: rtl/fdms_timer.sv
// Down-counting operation timer of the flash sequencer
`include "fdms_cfg.svh"
module fdms_timer (
	input wire logic clk, // System clock
	input wire logic rst, // Asynchronous reset, high
	input wire logic load, // Start a wait
	input wire fdms_pkg::fdms_cnt_t count, // Wait length in cycles, at least one
	output logic done, // Last cycle of the wait
	output logic running // Wait in progress
);
	import fdms_pkg::*;

	fdms_cnt_t cnt_reg;
	fdms_cnt_t cnt_next;
	logic run_reg;
	logic run_next;

	// Done is combinational so the owner finishes on the last counted edge
	assign done = run_reg && (cnt_reg == fdms_cnt_t'(1));
	assign running = run_reg;

	// Next count
	always_comb begin
		cnt_next = cnt_reg;
		run_next = run_reg;
		if (load) begin
			cnt_next = count;
			run_next = 1'b1;
		end else if (run_reg) begin
			cnt_next = cnt_reg - fdms_cnt_t'(1);
			if (cnt_reg == fdms_cnt_t'(1)) begin
				run_next = 1'b0;
			end
		end
	end

	// Count registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			run_reg <= run_next;
		end
	end
endmodule

// File: sim/fdms_monitor.sv
// Checker of the register port between the core end and the sequencer end
module fdms_monitor (
	input wire logic CLK, // Clock
	input wire logic RST, // Reset, high
	input wire logic sfr_wr, // Write strobe
	input wire logic sfr_rd, // Read strobe
	input wire fdms_pkg::fdms_sel_t sfr_sel, // Select
	input wire fdms_pkg::fdms_byte_t sfr_wdata, // Write data
	input wire fdms_pkg::fdms_byte_t sfr_rdata, // Read data
	input wire logic busy // Stall
);
	import fdms_pkg::*;
	// ----------------------------------------
	// Run length, last command, target mode
	// ----------------------------------------
	fdms_cnt_t run_reg, run_next;
	fdms_byte_t cmd_reg, cmd_next;
	logic pm_reg, pm_next, go;
	assign go = sfr_wr && sfr_sel == 3'h0 && !busy; // Writes while busy are dropped
	// Next values of the helpers
	always_comb begin
		run_next = busy ? run_reg + 20'h1 : 20'h0;
		cmd_next = go ? sfr_wdata : cmd_reg;
		pm_next = (go && sfr_wdata == 8'hf0) || (pm_reg && !(go && sfr_wdata == 8'h0f));
	end
	// Helper registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			run_reg <= 20'h0;
			cmd_reg <= 8'h00;
			pm_reg <= 1'b0;
		end else begin
			run_reg <= run_next;
			cmd_reg <= cmd_next;
			pm_reg <= pm_next;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	start_busy_a: assert property (go && sfr_wdata inside {8'h02, 8'h05, 8'h06, 8'h82} |=> busy)
		else $error("op did not start");
	resv_code_a: assert property (go && sfr_wdata == 8'h03 |=> !busy)
		else $error("reserved code started");
	mode_switch_a: assert property (go && sfr_wdata inside {8'h0f, 8'hf0} |=> !busy)
		else $error("mode code started");
	pm_refuse_a: assert property (go && pm_reg && sfr_wdata inside {8'h01, 8'h04, 8'h81} |=> !busy)
		else $error("program mode op started");
	busy_cause_a: assert property ($rose(busy) |-> $past(go))
		else $error("busy without command");
	erase_len_a: assert property ($fell(busy) && cmd_reg == 8'h06 && !pm_reg |-> run_reg >= 20'd1024)
		else $error("full erase short");
	read_len_a: assert property ($fell(busy) && !pm_reg && cmd_reg inside {8'h01, 8'h04} |-> run_reg == 20'd22)
		else $error("page read time");
	byte_len_a: assert property ($fell(busy) && !pm_reg && cmd_reg == 8'h81 |-> run_reg == 20'd9)
		else $error("byte read time");
endmodule

// File: sim/tb_top.sv
// Self-checking bench joining the core end and the sequencer end
`include "fdms_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fdms_pkg::*;
	// ----------------------------------------
	// Signals, instances, tasks
	// ----------------------------------------
	localparam logic [32:0] ER = 33'h1_0000_0000;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, irq_take, pm;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, d0, d1, v, rd;
	logic [15:0] pcount, pc_last;
	logic rq = 1'b1, irq_q = 1'b0; // Reset and interrupt request as seen at the last edge
	logic [32:0] qe[$], qm[$];
	int err_total = 0, n_tests = 0, nb = 0, cyc = 0;
	fdms_if ifc ();
	fdms_core fdms_core_inst (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SFR(ifc));
	fdms_flash #(.P_WRPAGE_CYC(40), .P_ERPAGE_CYC(50), .P_ERALL_CYC(60),
		.P_PM_WRPAGE_CYC(70), .P_PM_ERALL_CYC(90))
		fdms_flash_inst (.CLK(clk), .RST(rst), .SFR(ifc), .IRQ_REQ(irq), .IRQ_TAKE(irq_take),
		.PROG_MODE(pm), .PERIPH_COUNT(pcount));
	fdms_monitor fdms_monitor_inst (.CLK(clk), .RST(rst), .sfr_wr(ifc.sfr_wr), .sfr_rd(ifc.sfr_rd),
		.sfr_sel(ifc.sfr_sel), .sfr_wdata(ifc.sfr_wdata), .sfr_rdata(ifc.sfr_rdata), .busy(ifc.busy));
	task automatic chk(logic [32:0] got, logic [32:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("mismatches %0d of %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// One transfer; expected {err, data} and mask go to the queue
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e, logic [32:0] m);
		qe.push_back(e);
		qm.push_back(m);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic idle();
		do apb(0, `FDMS_APB_STAT, 0, 0, 0); while (rd[0] !== 1'b0);
	endtask
	// Command, optional refused second command, then busy length
	task automatic op(logic [7:0] c, int n, bit rf = 0);
		int n0;
		n0 = nb;
		apb(1, `FDMS_APB_CMD, {24'h0, c}, 0, ER);
		if (rf) begin
			repeat (20) @(posedge clk);
			apb(1, `FDMS_APB_CMD, 32'h1, ER, ER);
		end
		idle();
		chk(33'(nb - n0), 33'(n));
	endtask
	// Clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Result watcher, stall side effects and timeout
	always @(posedge clk) begin
		cyc++;
		if (psel && penable && pready) chk({pslverr, prdata} & qm.pop_front(), qe.pop_front());
		if (ifc.busy === 1'b1) begin
			nb++;
			chk({32'h0, irq_take}, 33'h0);
			chk({17'h0, pcount}, {17'h0, 16'(pc_last + 16'h1)});
		end
		// Idle: interrupt passes through one register stage
		if (!rq && ifc.busy !== 1'b1) chk({32'h0, irq_take}, {32'h0, irq_q});
		pc_last = pcount;
		rq = rst;
		irq_q = irq;
		irq <= 1'($urandom);
		if (cyc > 30000) begin
			err_total++;
			stop_test();
		end
	end
	// Main sequence
	initial begin
		void'($urandom(32'h9265));
		{rst, psel, penable, pwrite, irq, paddr, pwdata} = {1'b1, 44'h0};
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		idle();
		d0 = $urandom;
		d1 = $urandom;
		apb(1, `FDMS_APB_ADDR, 32'h3, 0, ER);
		apb(1, `FDMS_APB_DATA, d0, 0, ER);
		op(8'h02, 40);
		op(8'h01, 22);
		apb(0, `FDMS_APB_DATA, 0, {1'b0, d0}, '1);
		apb(1, `FDMS_APB_DATA, d1, 0, ER);
		op(8'h02, 40);
		op(8'h01, 22);
		apb(0, `FDMS_APB_DATA, 0, {1'b0, d0 & d1}, '1);
		for (int k = 0; k < 2; k++) begin
			v = k ? d0 : d0 & d1;
			apb(1, `FDMS_APB_DATA, v, 0, ER);
			op(8'h04, 22);
			apb(0, `FDMS_APB_STAT, 0, {17'h0, v !== (d0 & d1) ? 8'h01 : 8'h00, 6'h0,
				v !== (d0 & d1), 1'b0}, 33'hffff);
		end
		op(8'h05, 50);
		op(8'h01, 22);
		apb(0, `FDMS_APB_DATA, 0, 33'hffff_ffff, '1);
		apb(1, `FDMS_APB_ADDR, 32'hc, 0, ER);
		op(8'h81, 9);
		apb(0, `FDMS_APB_DATA, 0, 33'hff, 33'hff);
		op(8'h82, 10000);
		op(8'h81, 9);
		apb(0, `FDMS_APB_DATA, 0, {25'h0, d0[7:0]}, 33'hff);
		op(8'h03, 0);
		apb(1, 8'h10, 0, ER, ER);
		// Fill the page read back below so the full erase has something to clear
		op(8'h02, 40);
		op(8'h06, 1024, 1);
		op(8'h01, 22);
		apb(0, `FDMS_APB_DATA, 0, 33'hffff_ffff, '1);
		op(8'hf0, 0);
		chk({32'h0, pm}, 33'h1);
		op(8'h01, 0);
		op(8'h02, 70);
		op(8'h06, 90);
		op(8'h0f, 0);
		op(8'h81, 9);
		stop_test();
	end
endmodule
